// ### hdl/pps_params.svh
/*
 * Constants for the port sequencer: strap codes, class limits and timing counts.
 * Assumes a 100 MHz system clock; included by the sequencer.
 */
// Function
// - Budget codes 011b to 111b power Class 4 and above over four pairs; with midspan_select_n low, code 011b caps the class at 3.
// - Class 3 and lower single-signature devices get only two pairs; dual-signature sets are powered one by one.
// - Code 010b powers up to two Class 4 ports, 36.2 W cutoff each.
// - Codes 010b and 001b make each pair set an independent port.
// - Two-pair operation never runs a connection check.
// - Leaving reset, boot, sample straps and latch the maximum class.
// - Undervoltage and over-temperature clear by themselves and resample the straps.
// - After boot test pass switches; a fault shows error and halts sequencing.
// - Four-pair: detect one set, then connection check decides single or dual.
// - Four-pair: then detect the other set; both valid before classifying.
// - Each classification opens with a class probe learning the requested power.
// - A class reset follows the probe before final classification.
// - Final classification opens with a long first class pulse, two-pair too.
// - Complete the class event sequence with the granted class, then apply power.
// - Starting pair set alternates after each error restart and each failed two-pair detection; four-pair retries the same set.
// - Dual signature: classify and power one set fully, then the other.
// - Held in reset, the controller idles and leaves the analog side alone.
// - Power stays on unsupervised; analog reset within 300 us after release. A fault or disconnect while waiting for it still removes power.
// - After the analog reset, detection restarts with the sampled strap setup.
// - First detection starts typically 45 ms after reset ends.
// - Indicator steady when powered, slow blink searching, fast blink on error.
// - Disconnect or fault removes power and restarts detection.
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH
`define PPS_CLK_MHZ          100
`define PPS_CODE_OFF         3'h0
`define PPS_CODE_2P_C3       3'h1
`define PPS_CODE_2P_C4       3'h2
`define PPS_CODE_4P_MIN      3'h3
`define PPS_CLASS_2P_MAX     4'h3
`define PPS_CUT_2P_C4_MW     17'h8d68
`define PPS_CUT_2P_C3_MW     17'h47e0
`define PPS_AN_RESET_US      300
`define PPS_AN_RESET_CYC     ((`PPS_AN_RESET_US * `PPS_CLK_MHZ))
`define PPS_BOOT_MS          45
`define PPS_BOOT_CYC         ((`PPS_BOOT_MS * 1000 * `PPS_CLK_MHZ))
`define PPS_SLOW_BLINK_MS    500
`define PPS_SLOW_BLINK_CYC   ((`PPS_SLOW_BLINK_MS * 1000 * `PPS_CLK_MHZ))
`define PPS_FAST_BLINK_MS    100
`define PPS_FAST_BLINK_CYC   ((`PPS_FAST_BLINK_MS * 1000 * `PPS_CLK_MHZ))
`endif

// ### hdl/pps_pkg.sv
/*
 * Types for the port sequencer.
 * Assumes the constants header is available on the include path.
 */
package pps_pkg;
  typedef enum logic [2:0]
  {
    PPS_OP_DETECT,
    PPS_OP_CONN_CHECK,
    PPS_OP_CLASS_PROBE,
    PPS_OP_CLASS_RESET,
    PPS_OP_CLASS_LONG,
    PPS_OP_CLASS_FULL,
    PPS_OP_FET_TEST,
    PPS_OP_ANALOG_RESET
  } pps_op_t;
endpackage

// ### hdl/pps_sequencer.sv
/*
 * Autonomous sequencer for one power-sourcing port with two pair sets.
 * Assumes an analog front end that executes each requested operation and
 * answers with a done pulse and a result; all inputs are synchronous to clk.
 */
`timescale 1ns/100ps
`include "pps_params.svh"
module pps_sequencer #(
  parameter int unsigned BOOT_CYC     = `PPS_BOOT_CYC,
  parameter int unsigned AN_RST_CYC   = `PPS_AN_RESET_CYC,
  parameter int unsigned SLOW_CYC     = `PPS_SLOW_BLINK_CYC,
  parameter int unsigned FAST_CYC     = `PPS_FAST_BLINK_CYC
) (
  // Clock and reset.
  input  wire logic           clk,
  input  wire logic           reset,
  // Configuration straps and supply events.
  input  wire logic [2:0]     power_budget_straps,
  input  wire logic           midspan_select_n,
  input  wire logic           uvlo_active,
  input  wire logic           overtemp_active,
  // Analog front end request.
  output logic                op_start,
  output pps_pkg::pps_op_t    op_kind,
  output logic                op_set,
  output logic [3:0]          op_grant_class,
  input  wire logic           op_done,
  input  wire logic           op_ok,
  input  wire logic           op_dual,
  input  wire logic [3:0]     op_class,
  // Pair set power and monitoring.
  output logic [1:0]          power_enable,
  output logic                four_pair_mode,
  output logic [16:0]         power_cutoff_limit,
  output logic [3:0]          max_class,
  input  wire logic [1:0]     port_disconnect,
  input  wire logic [1:0]     port_fault,
  // Status indicator.
  output logic                status_led
);
  import pps_pkg::*;

  typedef enum logic [3:0]
  {
    PPS_BOOT, PPS_AN_RESET, PPS_FET, PPS_HALT, PPS_DET1, PPS_CONN, PPS_DET2,
    PPS_PROBE, PPS_CRESET, PPS_LONG, PPS_FULL, PPS_POWERED, PPS_ERROR, PPS_HOLD
  } pps_state_t;

  pps_state_t  state_q;
  logic [31:0] wait_q;
  logic        issued_q;
  logic [2:0]  code_q;
  logic        mid_q;
  logic        start_set_q;
  logic        cur_set_q;
  logic        dual_q;
  logic        second_q;
  logic [3:0]  req_class_q;
  logic [1:0]  pwr_q;
  logic        supply_bad_q;
  logic [31:0] blink_q;
  logic        blink_q_led;
  logic        four_pair;
  logic        supply_bad;
  logic        fault_any;
  logic [3:0]  grant;

  assign four_pair  = (code_q >= `PPS_CODE_4P_MIN);
  assign supply_bad = uvlo_active | overtemp_active;
  assign fault_any  = |((port_disconnect | port_fault) & pwr_q);
  assign grant      = (req_class_q < max_class) ? req_class_q : max_class;

  // Strap sampling at reset release and on auto-clear of supply events.
  always_ff @(posedge clk)
  begin
    if (reset)
      supply_bad_q <= 1'b0;
    else
      supply_bad_q <= supply_bad;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      code_q <= `PPS_CODE_OFF;
      mid_q  <= 1'b1;
    end
    else if (state_q == PPS_HOLD || state_q == PPS_BOOT || (supply_bad_q && !supply_bad))
    begin
      code_q <= power_budget_straps;
      mid_q  <= midspan_select_n;
    end
  end

  // Maximum grantable class and cutoff for two-pair codes.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      max_class          <= 4'h0;
      power_cutoff_limit <= 17'h0;
    end
    else
    begin
      case (code_q)
        `PPS_CODE_2P_C4:
        begin
          max_class          <= 4'h4;
          power_cutoff_limit <= `PPS_CUT_2P_C4_MW;
        end
        `PPS_CODE_2P_C3:
        begin
          max_class          <= 4'h3;
          power_cutoff_limit <= `PPS_CUT_2P_C3_MW;
        end
        `PPS_CODE_OFF:
        begin
          max_class          <= mid_q ? 4'h8 : 4'h7;
          power_cutoff_limit <= 17'h0;
        end
        default:
        begin
          max_class          <= mid_q ? ({1'b0, code_q} + 4'h1) : {1'b0, code_q};
          power_cutoff_limit <= 17'h0;
        end
      endcase
    end
  end

  // Main sequence.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q     <= PPS_HOLD;
      wait_q      <= 32'h0;
      issued_q    <= 1'b0;
      start_set_q <= 1'b0;
      cur_set_q   <= 1'b0;
      dual_q      <= 1'b0;
      second_q    <= 1'b0;
      req_class_q <= 4'h0;
      op_start    <= 1'b0;
      op_kind     <= PPS_OP_FET_TEST;
      op_set      <= 1'b0;
      op_grant_class <= 4'h0;
    end
    else
    begin
      op_start <= 1'b0;
      if (fault_any && state_q != PPS_HOLD)
      begin
        pwr_q    <= 2'b00;
        issued_q <= 1'b0;
        state_q  <= PPS_ERROR;
        wait_q   <= 32'h0;
      end
      else if (supply_bad && state_q != PPS_HOLD)
      begin
        pwr_q    <= 2'b00;
        issued_q <= 1'b0;
        state_q  <= PPS_BOOT;
      end
      else if (state_q == PPS_HOLD || state_q == PPS_BOOT || state_q == PPS_ERROR)
      begin
        // The first cycle out of reset leaves power untouched until the analog reset.
        state_q <= (state_q == PPS_HOLD) ? PPS_AN_RESET : (state_q == PPS_ERROR ? PPS_DET1 : PPS_FET);
        wait_q  <= 32'h0;
        if (state_q == PPS_ERROR)
        begin
          start_set_q <= ~start_set_q;
          cur_set_q   <= ~start_set_q;
        end
      end
      else if (state_q == PPS_AN_RESET)
      begin
        wait_q <= wait_q + 32'h1;
        if (wait_q == AN_RST_CYC - 1 && !issued_q)
        begin
          op_start <= 1'b1;
          op_kind  <= PPS_OP_ANALOG_RESET;
          pwr_q    <= 2'b00;
          issued_q <= 1'b1;
        end
        if (wait_q == BOOT_CYC - 1)
        begin
          issued_q <= 1'b0;
          state_q  <= PPS_FET;
        end
      end
      else if (state_q == PPS_HALT || state_q == PPS_POWERED)
      begin
        issued_q <= 1'b0;
      end
      else if (!issued_q)
      begin
        op_start <= 1'b1;
        issued_q <= 1'b1;
        op_set   <= (state_q == PPS_CONN) ? start_set_q : cur_set_q;
        op_grant_class <= grant;
        case (state_q)
          PPS_FET:    op_kind <= PPS_OP_FET_TEST;
          PPS_DET1:   op_kind <= PPS_OP_DETECT;
          PPS_DET2:   op_kind <= PPS_OP_DETECT;
          PPS_CONN:   op_kind <= PPS_OP_CONN_CHECK;
          PPS_PROBE:  op_kind <= PPS_OP_CLASS_PROBE;
          PPS_CRESET: op_kind <= PPS_OP_CLASS_RESET;
          PPS_LONG:   op_kind <= PPS_OP_CLASS_LONG;
          default:    op_kind <= PPS_OP_CLASS_FULL;
        endcase
      end
      else if (op_done)
      begin
        issued_q <= 1'b0;
        case (state_q)
          PPS_FET:
            state_q <= op_ok ? PPS_DET1 : PPS_HALT;
          PPS_DET1:
            if (!op_ok)
            begin
              // Two-pair ports search independently, so the other set gets its turn.
              cur_set_q <= four_pair ? cur_set_q : ~cur_set_q;
              start_set_q <= four_pair ? start_set_q : ~cur_set_q;
            end
            else
              state_q <= four_pair ? PPS_CONN : PPS_PROBE;
          PPS_CONN:
          begin
            dual_q    <= op_dual;
            cur_set_q <= ~start_set_q;
            state_q   <= op_ok ? PPS_DET2 : PPS_DET1;
          end
          PPS_DET2:
          begin
            cur_set_q <= start_set_q;
            second_q  <= 1'b0;
            state_q   <= op_ok ? PPS_PROBE : PPS_DET1;
          end
          PPS_PROBE:
          begin
            req_class_q <= op_class;
            state_q     <= PPS_CRESET;
          end
          PPS_CRESET:
            state_q <= PPS_LONG;
          PPS_LONG:
            state_q <= PPS_FULL;
          default:
          begin
            if (!four_pair || dual_q || grant <= `PPS_CLASS_2P_MAX)
              pwr_q[cur_set_q] <= 1'b1;
            else
              pwr_q <= 2'b11;
            if (four_pair && dual_q && !second_q)
            begin
              second_q  <= 1'b1;
              cur_set_q <= ~cur_set_q;
              state_q   <= PPS_PROBE;
            end
            else if (!four_pair && !pwr_q[~cur_set_q])
            begin
              cur_set_q <= ~cur_set_q;
              state_q   <= PPS_DET1;
            end
            else
              state_q <= PPS_POWERED;
          end
        endcase
      end
    end
  end

  assign power_enable   = pwr_q;
  assign four_pair_mode = four_pair;

  // Indicator blink timing.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      blink_q     <= 32'h0;
      blink_q_led <= 1'b0;
    end
    else if (blink_q >= ((state_q == PPS_HALT || state_q == PPS_ERROR) ? FAST_CYC : SLOW_CYC) / 2 - 1)
    begin
      blink_q     <= 32'h0;
      blink_q_led <= ~blink_q_led;
    end
    else
      blink_q <= blink_q + 32'h1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      status_led <= 1'b0;
    else if (state_q == PPS_POWERED || (pwr_q != 2'b00 && state_q != PPS_HALT))
      status_led <= 1'b1;
    else
      status_led <= blink_q_led;
  end

endmodule // pps_sequencer

// ### bench/pps_sequencer_asserts.sv
/* Concurrent checks on the ports of the port sequencer.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/100ps
module pps_seq_asserts
  import pps_pkg::*;
#(
  parameter int unsigned AN_RST_CYC = 50,
  parameter int unsigned BOOT_CYC   = 200
)
(
  // Clock and reset.
  input wire logic             clk,
  input wire logic             reset,
  // Front end handshake.
  input wire logic             op_start,
  input wire pps_pkg::pps_op_t op_kind,
  input wire logic [3:0]       op_grant_class,
  input wire logic             op_done,
  input wire logic             op_ok,
  // Power and configuration.
  input wire logic [1:0]       power_enable,
  input wire logic             four_pair_mode,
  input wire logic [3:0]       max_class,
  input wire logic [1:0]       port_fault
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [15:0] age_q;
  always_ff @(posedge clk)
  begin
    if (reset) age_q <= 16'h0;
    else if (age_q != 16'hffff) age_q <= age_q + 16'h1;
  end
  sequence s_fet_fail;
    op_done && !op_ok && op_kind == PPS_OP_FET_TEST;
  endsequence
  sequence s_start(pps_op_t k);
    op_start && op_kind == k;
  endsequence
  chk_halt_quiet: assert property (s_fet_fail |=> !op_start [*8])
    else $error("request after switch fault");
  chk_no_conn_2p: assert property (op_start && !four_pair_mode |-> op_kind != PPS_OP_CONN_CHECK)
    else $error("connection check in two-pair mode");
  chk_reset_probe: assert property (s_start(PPS_OP_CLASS_RESET) |-> $past(op_kind) == PPS_OP_CLASS_PROBE)
    else $error("class reset without probe");
  chk_long_reset: assert property (s_start(PPS_OP_CLASS_LONG) |-> $past(op_kind) == PPS_OP_CLASS_RESET)
    else $error("long pulse without class reset");
  chk_full_long: assert property (s_start(PPS_OP_CLASS_FULL) |-> $past(op_kind) == PPS_OP_CLASS_LONG)
    else $error("full sequence without long pulse");
  chk_power_full: assert property ($rose(power_enable[0]) |-> $past(op_kind) == PPS_OP_CLASS_FULL)
    else $error("power applied before classification");
  chk_grant_cap: assert property (s_start(PPS_OP_CLASS_FULL) |-> op_grant_class <= max_class)
    else $error("grant above maximum class");
  chk_fault_drop: assert property (port_fault[0] && power_enable[0] |-> ##[1:2] !power_enable[0])
    else $error("power kept after fault");
  chk_an_reset_time: assert property (s_start(PPS_OP_ANALOG_RESET) && age_q < 16'd1000 |->
    32'(age_q) + 1 >= AN_RST_CYC && 32'(age_q) <= AN_RST_CYC + 1)
    else $error("analog reset at wrong time");
  chk_boot_time: assert property (s_start(PPS_OP_FET_TEST) |-> 32'(age_q) + 1 >= BOOT_CYC)
    else $error("switch test before boot time");
endmodule // pps_seq_asserts
bind pps_sequencer pps_seq_asserts #(.AN_RST_CYC(AN_RST_CYC), .BOOT_CYC(BOOT_CYC)) u_chk (.clk(clk), .reset(reset),
  .op_start(op_start), .op_kind(op_kind), .op_grant_class(op_grant_class), .op_done(op_done), .op_ok(op_ok),
  .power_enable(power_enable), .four_pair_mode(four_pair_mode), .max_class(max_class), .port_fault(port_fault));

// ### bench/pps_front_end_model.sv
/* Behavioural analog front end answering each sequencer request.
   Assumes requests are single-cycle pulses on clk. */
`timescale 1ns/100ps
module pps_front_end_model
  import pps_pkg::*;
(
  // Clock and request.
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             op_start,
  input  wire pps_pkg::pps_op_t op_kind,
  // Behaviour chosen by the bench.
  input  wire logic             fet_bad,
  input  wire logic             dual,
  input  wire logic             slow,
  input  wire logic [3:0]       req_class,
  // Answers.
  output logic                  op_done,
  output logic                  op_ok,
  output logic                  op_dual,
  output logic [3:0]            op_class
);
  pps_op_t    kind_q;
  logic [3:0] wait_q;
  logic       busy_q;
  logic       tog_q = 1'b0;
  always @(posedge clk)
  begin
    tog_q <= ~tog_q;
    op_done <= 1'b0;
    if (reset) busy_q <= 1'b0;
    else if (op_start)
    begin
      busy_q <= 1'b1;
      kind_q <= op_kind;
      wait_q <= slow ? 4'h7 : 4'h0;
    end
    else if (busy_q && wait_q != 4'h0) wait_q <= wait_q - 4'h1;
    else if (busy_q)
    begin
      busy_q <= 1'b0;
      op_done <= 1'b1;
    end
  end
  // Results are only meaningful with the done pulse; otherwise they wander.
  assign op_ok    = op_done ? !(fet_bad && kind_q == PPS_OP_FET_TEST) : tog_q;
  assign op_dual  = op_done ? dual : tog_q;
  assign op_class = op_done ? req_class : {4{tog_q}};
endmodule // pps_front_end_model

// ### bench/pps_sequencer_bench.sv
/* Self-checking bench for the port sequencer.
   Assumes shortened boot, reset and blink counts set at the instance. */
`timescale 1ns/100ps
`define CHK(w, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", w, e, g); end end
module pps_sequencer_bench;
  import pps_pkg::*;
  localparam pps_op_t K_AR = PPS_OP_ANALOG_RESET, K_FT = PPS_OP_FET_TEST, K_DT = PPS_OP_DETECT,
    K_CC = PPS_OP_CONN_CHECK, K_PR = PPS_OP_CLASS_PROBE, K_CR = PPS_OP_CLASS_RESET,
    K_LG = PPS_OP_CLASS_LONG, K_FL = PPS_OP_CLASS_FULL;
  logic        clk = 0, reset = 1, mid_n = 1, uvlo = 0, otemp = 0, fet_bad = 0, dual = 0, slow = 0;
  logic [2:0]  straps = 3'h7;
  logic [3:0]  req = 4'h8, grant, maxc, op_class;
  logic [1:0]  pwr, disc = 2'h0, flt = 2'h0;
  logic [16:0] cut;
  logic        op_start, op_set, op_done, op_ok, op_dual, fourp, led;
  pps_op_t     op_kind, kq[$];
  logic        sq[$];
  logic [3:0]  gq[$];
  int          err_count = 0, n_checks = 0;
  always #5 clk = ~clk;
  pps_sequencer #(.BOOT_CYC(200), .AN_RST_CYC(50), .SLOW_CYC(40), .FAST_CYC(10)) dut (.clk(clk), .reset(reset),
    .power_budget_straps(straps), .midspan_select_n(mid_n), .uvlo_active(uvlo), .overtemp_active(otemp),
    .op_start(op_start), .op_kind(op_kind), .op_set(op_set), .op_grant_class(grant), .op_done(op_done),
    .op_ok(op_ok), .op_dual(op_dual), .op_class(op_class), .power_enable(pwr), .four_pair_mode(fourp),
    .power_cutoff_limit(cut), .max_class(maxc), .port_disconnect(disc), .port_fault(flt), .status_led(led));
  pps_front_end_model fe (.clk(clk), .reset(reset), .op_start(op_start), .op_kind(op_kind), .fet_bad(fet_bad),
    .dual(dual), .slow(slow), .req_class(req), .op_done(op_done), .op_ok(op_ok), .op_dual(op_dual),
    .op_class(op_class));
  always @(negedge clk)
    if (op_start === 1'b1)
    begin
      kq.push_back(op_kind);
      sq.push_back(op_set);
      gq.push_back(grant);
    end
  task automatic boot(input logic [2:0] code, input logic dl, input logic [3:0] rc, input logic fb);
    @(negedge clk);
    {straps, dual, req, fet_bad, reset} = {code, dl, rc, fb, 1'b1};
    repeat (5) @(negedge clk);
    kq.delete(); sq.delete(); gq.delete();
    reset = 0;
  endtask
  task automatic wait_ops(input int n);
    for (int i = 0; i < 3000 && kq.size() < n; i++) @(negedge clk);
    `CHK("op count", 1'b1, kq.size() >= n)
    repeat (3) @(negedge clk);
  endtask
  task automatic chk_seq(input pps_op_t e[$]);
    foreach (e[i]) `CHK("op kind", e[i], kq[i])
  endtask
  task automatic led_run(output int hi, output int tg);
    logic last;
    {hi, tg, last} = {32'h0, 32'h0, led};
    repeat (60)
    begin
      @(negedge clk);
      hi += led;
      tg += (led !== last);
      last = led;
    end
  endtask
  task automatic t_hold();
    reset = 1;
    kq.delete();
    repeat (100) @(negedge clk);
    `CHK("ops in reset", 0, kq.size())
  endtask
  task automatic t_four_single();
    int hi, tg;
    boot(3'h7, 0, 4'h8, 0);
    wait_ops(9);
    chk_seq('{K_AR, K_FT, K_DT, K_CC, K_DT, K_PR, K_CR, K_LG, K_FL});
    `CHK("second set", ~sq[2], sq[4])
    `CHK("grant", 4'h8, gq[8])
    `CHK("power", 2'h3, pwr)
    `CHK("max class", 4'h8, maxc)
    `CHK("four pair", 1'b1, fourp)
    led_run(hi, tg);
    `CHK("led steady", 60, hi)
    flt = 2'h1;
    @(negedge clk);
    flt = 2'h0;
    repeat (3) @(negedge clk);
    `CHK("power off", 2'h0, pwr)
    wait_ops(10);
    `CHK("restart", K_DT, kq[9])
    `CHK("start set", ~sq[2], sq[9])
  endtask
  task automatic t_supply();
    uvlo = 1;
    repeat (3) @(negedge clk);
    `CHK("uvlo power", 2'h0, pwr)
    straps = 3'h1;
    uvlo = 0;
    repeat (5) @(negedge clk);
    `CHK("uvlo resample", 17'd18400, cut)
    otemp = 1;
    straps = 3'h7;
    repeat (3) @(negedge clk);
    otemp = 0;
    repeat (5) @(negedge clk);
    `CHK("otemp resample", 1'b1, fourp)
  endtask
  task automatic t_dual_slow();
    slow = 1;
    boot(3'h7, 1, 4'h5, 0);
    wait_ops(13);
    chk_seq('{K_AR, K_FT, K_DT, K_CC, K_DT, K_PR, K_CR, K_LG, K_FL, K_PR, K_CR, K_LG, K_FL});
    `CHK("dual sets", ~sq[8], sq[12])
    repeat (10) @(negedge clk);
    `CHK("dual power", 2'h3, pwr)
    slow = 0;
  endtask
  task automatic t_low_class();
    boot(3'h3, 0, 4'h3, 0);
    wait_ops(9);
    `CHK("class3 pairs", 1, $countones(pwr))
    boot(3'h2, 0, 4'h4, 0);
    wait_ops(7);
    chk_seq('{K_AR, K_FT, K_DT, K_PR, K_CR, K_LG, K_FL});
    `CHK("cutoff c4", 17'd36200, cut)
    `CHK("grant c4", 4'h4, gq[6])
    `CHK("one port", 1, $countones(pwr))
    `CHK("two pair", 1'b0, fourp)
    boot(3'h1, 0, 4'h4, 0);
    wait_ops(7);
    `CHK("grant c3", 4'h3, gq[6])
    disc = pwr;
    repeat (3) @(negedge clk);
    `CHK("disconnect", 2'h0, pwr & disc)
    disc = 2'h0;
  endtask
  task automatic t_fet_fault();
    int hi, tg;
    boot(3'h7, 0, 4'h8, 1);
    wait_ops(2);
    led_run(hi, tg);
    `CHK("halted", 2, kq.size())
    `CHK("fast blink", 1'b1, tg >= 4)
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(negedge clk);
    err_count++;
    print_verdict();
  end
  initial
  begin
    t_hold();
    t_four_single();
    t_supply();
    t_dual_slow();
    t_low_class();
    t_fet_fault();
    print_verdict();
  end
endmodule // pps_sequencer_bench
